/* phy_regs_cfg.svh */
// Offsets, field positions and reset values for the PHY speed and advertisement registers
`ifndef PHY_REGS_CFG_SVH
`define PHY_REGS_CFG_SVH
`define OFS_SPEED_STATUS 12'h000
`define OFS_ADVERT 12'h004
`define OFS_LINK_MODE 12'h008
`define SPD_CODE_LSB 2
`define SPD_CODE_MSB 4
`define STATUS_RSV6_BIT 6
`define STATUS_WMASK 16'h0040
`define STATUS_RESET 16'h0040
`define ADV_NP_BIT 15
`define ADV_RF_BIT 13
`define ADV_PAUSE_LSB 10
`define ADV_PAUSE_MSB 11
`define ADV_ABIL_LSB 5
`define ADV_ABIL_MSB 8
`define ADV_SEL_LSB 0
`define ADV_SEL_MSB 4
`define ADV_WMASK 16'h2DFF
`define ADV_RESET 16'h01E1
`endif

/* phy_regs_pkg.sv */
// Types shared by the PHY register bank
package phy_regs_pkg;
  typedef enum logic [2:0] {
    SpdRsv0 = 3'h0,
    SpdSlowHalf = 3'h1,
    SpdFastHalf = 3'h2,
    SpdRsv3 = 3'h3,
    SpdRsv4 = 3'h4,
    SpdSlowFull = 3'h5,
    SpdFastFull = 3'h6,
    SpdRsv7 = 3'h7
  } speed_duplex_code_e;

  typedef struct packed {
    logic adv_remote_fault;
    logic [1:0] adv_pause_ability;
    logic adv_fast_full;
    logic adv_fast_half;
    logic adv_slow_full;
    logic adv_slow_half;
    logic [4:0] adv_selector_field;
  } advert_s;

  typedef struct packed {
    logic linkUp;
    logic fast;
    logic full;
  } link_mode_s;
endpackage

/* phy_speed_advert_props.sv */
// Concurrent checks on the PHY speed and advertisement register bank
`timescale 1ns/1ns
`include "phy_regs_cfg.svh"
module phy_speed_advert_props
  import phy_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Link and advert
  input wire logic linkUpIn,
  input wire logic linkFastIn,
  input wire logic linkFullIn,
  input advert_s advert
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic tk = hsel && hready && htrans[1];
  wire logic rdSt = tk && !hwrite && haddr == `OFS_SPEED_STATUS;
  wire logic rdAdv = tk && !hwrite && haddr == `OFS_ADVERT;
  wire logic [2:0] mode = {linkUpIn, linkFastIn, linkFullIn};
  sequence wrAdv;
    tk && hwrite && haddr == `OFS_ADVERT ##1 1'h1;
  endsequence
  // Sync delay is three edges, five stable cycles leave margin
  sequence settledRead;
    $stable(mode)[*5] ##0 rdSt;
  endsequence
  a_np_zero: assert property (rdAdv |=> !hrdata[15])
    else $error("next page bit reads one");
  a_pause_wr: assert property (wrAdv |=> advert.adv_pause_ability == $past(hwdata[11:10]))
    else $error("pause field not written");
  a_fault_wr: assert property (wrAdv |=> advert.adv_remote_fault == $past(hwdata[13]))
    else $error("fault bit not written");
  a_abil_wr: assert property (wrAdv |=> {advert.adv_fast_full, advert.adv_fast_half,
    advert.adv_slow_full, advert.adv_slow_half} == $past(hwdata[8:5]))
    else $error("ability bits not written");
  a_code_legal: assert property (rdSt |=> hrdata[4:2] inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6})
    else $error("reserved speed code read");
  a_code_track: assert property (settledRead |=> hrdata[4:2] ==
    ($past(mode[2]) ? {$past(mode[0]), $past(mode[1]), !$past(mode[1])} : 3'h0))
    else $error("speed code does not follow link");
endmodule
bind phy_speed_advert_regs phy_speed_advert_props u_props (.clk, .rst_n, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .linkUpIn, .linkFastIn,
  .linkFullIn, .advert);

/* phy_speed_advert_regs.sv */
// AHB-Lite register bank: speed/duplex status and auto-negotiation advertisement
//
// Overview of operation
// - Bits 4-2 report speed and duplex code
// - Next-page bit reads zero, read-only
// - Writable PAUSE field bits 11-10, reset zero
// - Writable remote-fault bit 13, reset zero
// - Writable ability bits 8-5 advertise modes
`timescale 1ns/1ns
`include "phy_regs_cfg.svh"
module phy_speed_advert_regs
  import phy_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Resolved link mode from the PHY core, asynchronous
  input wire logic linkUpIn,
  input wire logic linkFastIn,
  input wire logic linkFullIn,
  // Advertisement fields toward the negotiation logic
  output advert_s advert
);
  ////////////////////////////////////////////////////////////////////////////
  // Link mode synchroniser
  link_mode_s modeMeta_q;
  link_mode_s modeSync_q;
  speed_duplex_code_e spdCode;

  // Mode pins belong to the PHY core clock, so two stages come first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeMeta_q <= '0;
      modeSync_q <= '0;
    end else begin
      modeMeta_q <= '{linkUp: linkUpIn, fast: linkFastIn, full: linkFullIn};
      modeSync_q <= modeMeta_q;
    end
  end

  speed_code_tracker u_tracker (
    .clk(clk),
    .rst_n(rst_n),
    .mode(modeSync_q),
    .code(spdCode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the write and read paths
  typedef enum logic [1:0] {
    SelNone,
    SelStatus,
    SelAdvert,
    SelLink
  } reg_sel_e;

  // Unmapped offsets fall to SelNone: reads give zero, writes are dropped
  function automatic reg_sel_e decodeAddr(input logic [11:0] addr);
    reg_sel_e sel;
    sel = SelNone;
    case (addr)
      `OFS_SPEED_STATUS: begin
        sel = SelStatus;
      end
      `OFS_ADVERT: begin
        sel = SelAdvert;
      end
      `OFS_LINK_MODE: begin
        sel = SelLink;
      end
      default: begin
        sel = SelNone;
      end
    endcase
    return sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address phase capture
  logic wrPend_q;
  logic [11:0] wrAddr_q;
  wire logic accept;
  wire logic isRead;
  wire logic wrPend_d;
  wire logic [11:0] wrAddr_d;

  // Zero wait states: a write lands at the end of its data phase
  assign accept = hsel && hready && htrans[1];
  assign isRead = accept && !hwrite;
  assign wrPend_d = accept && hwrite;
  assign wrAddr_d = accept ? haddr : wrAddr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 12'h000;
    end else begin
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [15:0] status_q;
  logic [15:0] advert_q;
  wire logic wrStatus;
  wire logic wrAdvert;
  wire reg_sel_e wrSel;
  wire logic [15:0] wrWord;
  wire logic [15:0] statusRead;
  wire logic [15:0] advertRead;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wr,
                                        input logic [15:0] mask);
    return (old & ~mask) | (wr & mask);
  endfunction

  // Upper half of the bus word carries no register bits
  assign wrWord = hwdata[15:0];
  assign wrSel = decodeAddr(wrAddr_q);
  assign wrStatus = wrPend_q && (wrSel == SelStatus);
  assign wrAdvert = wrPend_q && (wrSel == SelAdvert);

  // Only bit 6 is stored; other reserved bits accept writes but hold zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= `STATUS_RESET;
    end else if (wrStatus) begin
      status_q <= merge(status_q, wrWord, `STATUS_WMASK);
    end
  end

  // Next-page and reserved bits are outside the write mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      advert_q <= `ADV_RESET;
    end else if (wrAdvert) begin
      advert_q <= merge(advert_q, wrWord, `ADV_WMASK);
    end
  end

  // Reserved status bits read as stored (zero except bit 6, which resets to one); software ignores them
  assign statusRead = {status_q[15:`SPD_CODE_MSB + 1], spdCode,
                       status_q[`SPD_CODE_LSB - 1:0]};
  assign advertRead = {1'b0, advert_q[14:0]};

  assign advert = '{
    adv_remote_fault: advert_q[`ADV_RF_BIT],
    adv_pause_ability: advert_q[`ADV_PAUSE_MSB:`ADV_PAUSE_LSB],
    adv_fast_full: advert_q[`ADV_ABIL_MSB],
    adv_fast_half: advert_q[`ADV_ABIL_MSB - 1],
    adv_slow_full: advert_q[`ADV_ABIL_LSB + 1],
    adv_slow_half: advert_q[`ADV_ABIL_LSB],
    adv_selector_field: advert_q[`ADV_SEL_MSB:`ADV_SEL_LSB]
  };

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered; unmapped addresses read zero
  logic [31:0] rdata_q;
  wire reg_sel_e rdSel;
  wire logic [15:0] rdWord;
  wire logic [15:0] linkView;
  wire logic [31:0] rdata_d;

  // Every select code is listed, so the case needs no default
  function automatic logic [15:0] pickWord(input reg_sel_e sel, input logic [15:0] st,
                                           input logic [15:0] adv, input logic [15:0] lnk);
    logic [15:0] word;
    word = 16'h0000;
    unique case (sel)
      SelStatus: begin
        word = st;
      end
      SelAdvert: begin
        word = adv;
      end
      SelLink: begin
        word = lnk;
      end
      SelNone: begin
        word = 16'h0000;
      end
    endcase
    return word;
  endfunction

  assign linkView = {13'h0000, modeSync_q.linkUp, modeSync_q.fast, modeSync_q.full};
  assign rdSel = decodeAddr(haddr);
  assign rdWord = pickWord(rdSel, statusRead, advertRead, linkView);
  // Held between reads, so the data phase never sees a later change
  assign rdata_d = isRead ? {16'h0000, rdWord} : rdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule

/* speed_code_tracker.sv */
// Tracks the resolved link mode and encodes it as the speed/duplex code
`timescale 1ns/1ns
module speed_code_tracker
  import phy_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Resolved mode, already synchronised
  input link_mode_s mode,
  // Encoded code
  output speed_duplex_code_e code
);
  speed_duplex_code_e code_q;
  wire speed_duplex_code_e code_d;

  // Link down has no defined code, so it reports the all-zero reserved value
  function automatic speed_duplex_code_e encode(input link_mode_s m);
    speed_duplex_code_e c;
    c = SpdRsv0;
    if (m.linkUp && m.fast && m.full) begin
      c = SpdFastFull;
    end else if (m.linkUp && m.fast) begin
      c = SpdFastHalf;
    end else if (m.linkUp && m.full) begin
      c = SpdSlowFull;
    end else if (m.linkUp) begin
      c = SpdSlowHalf;
    end
    return c;
  endfunction

  assign code_d = encode(mode);

  // Refreshed every cycle so a read shows the present mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= SpdRsv0;
    end else begin
      code_q <= code_d;
    end
  end

  assign code = code_q;
endmodule

/* tb_phy_speed_advert_regs.sv */
// Self-checking bench for the PHY speed and advertisement register bank
`timescale 1ns/1ns
`include "phy_regs_cfg.svh"
module tb_phy_speed_advert_regs
  import phy_regs_pkg::*;
;
  logic clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic linkUp = 1'h0, linkFast = 1'h0, linkFull = 1'h0, hreadyout, hresp;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, e;
  logic [31:0] hwdata = 32'h0, hrdata, rd, d;
  advert_s advert;
  int num_errors = 0, checks_done = 0, cyc = 0, advM = 32'h1E1;
  always #2 clk = ~clk;
  phy_speed_advert_regs u_dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .linkUpIn(linkUp),
    .linkFastIn(linkFast), .linkFullIn(linkFull), .advert);
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
    chk(rd[31:16], 16'h0000);
    chk({15'h0000, hresp}, 16'h0000);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, the whole run needs under 130 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    void'($urandom(32'hFED9));
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    xfer(0, `OFS_SPEED_STATUS, 0);
    chk(rd[15:0], 16'h0040);
    xfer(0, 12'h00C, 0);
    chk(rd[15:0], 16'h0000);
    xfer(1, `OFS_SPEED_STATUS, 32'h0040);
    xfer(0, `OFS_ADVERT, 0);
    chk(rd[15:0], `ADV_RESET);
    for (int i = 0; i < 12; i++) begin
      // First pass sets every bit, second goes to an unmapped slot
      d = (i == 0) ? 32'hFFFF : $urandom;
      xfer(1, (i == 1) ? 12'h010 : `OFS_ADVERT, d);
      if (i != 1) advM = d & 32'h2DFF;
      xfer(0, `OFS_ADVERT, 0);
      chk(rd[15:0], advM[15:0]);
      chk({4'h0, advert}, {4'h0, advM[13], advM[11:10], advM[8:0]});
    end
    xfer(0, `OFS_ADVERT, 0);
    chk(rd[15:0], advM[15:0]);
    for (int m = 0; m < 8; m++) begin
      {linkUp, linkFast, linkFull} <= m[2:0];
      repeat (3) @(posedge clk);
      e = m[2] ? {m[0], m[1], !m[1]} : 3'h0;
      xfer(0, `OFS_LINK_MODE, 0);
      chk(rd[15:0], {13'h0000, m[2:0]});
      xfer(0, `OFS_SPEED_STATUS, 0);
      chk(rd[15:0], {9'h0, 1'h1, 1'h0, e, 2'h0});
    end
    // Mid-run reset must bring every field back to its power-on value
    {linkUp, linkFast, linkFull} <= 3'h0;
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    xfer(0, `OFS_ADVERT, 0);
    chk(rd[15:0], `ADV_RESET);
    chk({4'h0, advert}, {4'h0, 1'h0, 2'h0, 4'hF, 5'h01});
    xfer(0, `OFS_SPEED_STATUS, 0);
    chk(rd[15:0], `STATUS_RESET);
    end_sim;
  end
endmodule
